// [hw/i2crsp_pkg.sv]
// Constants and types for the two-wire register port bus master
// Function
// - Only the master drives the clock line; the device never does.
// - Clock at standard 100 kHz or fast 400 kHz, chosen per command.
// - Data changes only while clock low, except start, repeated start, stop.
// - Data falling with clock high is start; rising with clock high is stop.
// - Seven-bit address, MSB first: fixed 10010b then two strap bits.
// - Write sends address+0, register address, data byte; each byte acknowledged.
// - After write acknowledge: stop, or repeated start into write or read.
// - Read: repeated start, resend address with direction 1, device acknowledges.
// - Device shifts out eight data bits; master returns an acknowledge bit.
// - After read: stop, or repeated start into write, read, or short read.
// - Device drives data only for acknowledges and read data bits.
package i2crsp_pkg;

   localparam int unsigned CLK_HZ   = 100_000_000;
   localparam int unsigned STD_HZ   = 100_000;
   localparam int unsigned FAST_HZ  = 400_000;
   localparam int unsigned QTR_W    = 12;
   // Quarter of the bus clock period, rounded up so the rate is never exceeded
   localparam int unsigned STD_QTR  = (CLK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ);
   localparam int unsigned FAST_QTR = (CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ);

   localparam logic [4:0] ADDR_PREFIX = 5'h12;
   localparam logic       DIR_WRITE   = 1'h0;
   localparam logic       DIR_READ    = 1'h1;

   localparam logic [1:0] KIND_WRITE = 2'h0;
   localparam logic [1:0] KIND_READ  = 2'h1;
   localparam logic [1:0] KIND_SHORT = 2'h2;

   localparam logic [1:0] PHASE_RST  = 2'h0;
   localparam logic [3:0] BIT_ACK    = 4'h8;
   localparam logic [2:0] STEP_RST   = 3'h0;
   localparam logic [7:0] BYTE_RST   = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_BIT,
      ST_STOP
   } i2crsp_state_t;

   typedef enum logic [2:0] {
      OP_START,
      OP_ADDRW,
      OP_ADDRR,
      OP_REG,
      OP_DATA,
      OP_RX,
      OP_FIN
   } i2crsp_op_t;

endpackage : i2crsp_pkg

// [hw/i2crsp_master.sv]
// Bus master that writes and reads the device registers over the two-wire port
`timescale 1ns/1ns
`default_nettype none
module i2crsp_master (
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   input  wire logic       cmd_valid_in,
   output logic            cmd_ready_out,
   input  wire logic [1:0] cmd_kind_in,
   input  wire logic [1:0] cmd_addr_sel_in,
   input  wire logic [7:0] cmd_reg_in,
   input  wire logic [7:0] cmd_data_in,
   input  wire logic       cmd_fast_in,
   input  wire logic       cmd_stop_in,
   output logic            done_out,
   output logic            nack_out,
   output logic [7:0]      rdata_out,
   output logic            busy_out,
   output logic            scl_out,
   output logic            scl_oe_out,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out
);

   i2crsp_pkg::i2crsp_state_t state;
   i2crsp_pkg::i2crsp_state_t next_state;
   i2crsp_pkg::i2crsp_op_t    op;
   i2crsp_pkg::i2crsp_op_t    nop;

   logic [i2crsp_pkg::QTR_W-1:0] qcnt;
   logic [i2crsp_pkg::QTR_W-1:0] next_qcnt;
   logic [1:0] phase;
   logic [1:0] next_phase;
   logic [2:0] step;
   logic [2:0] next_step;
   logic [3:0] bitcnt;
   logic [3:0] next_bitcnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic [1:0] kind;
   logic [1:0] next_kind;
   logic [1:0] addr_sel;
   logic [1:0] next_addr_sel;
   logic [7:0] regb;
   logic [7:0] next_regb;
   logic [7:0] datab;
   logic [7:0] next_datab;
   logic       fast;
   logic       next_fast;
   logic       stop;
   logic       next_stop;
   logic       scl_low;
   logic       next_scl_low;
   logic       sda_low;
   logic       next_sda_low;
   logic       nack;
   logic       next_nack;
   logic       done;
   logic       next_done;
   logic       sda_meta;
   logic       sda_sync;
   logic       tick;
   logic       adv;
   logic       is_rx;

   function automatic logic [i2crsp_pkg::QTR_W-1:0] qtr_of(input logic f);
      qtr_of = f ? i2crsp_pkg::QTR_W'(i2crsp_pkg::FAST_QTR - 1)
                 : i2crsp_pkg::QTR_W'(i2crsp_pkg::STD_QTR - 1);
   endfunction : qtr_of

   // Sequence of bus operations for each command kind
   function automatic i2crsp_pkg::i2crsp_op_t op_of(input logic [1:0] k,
                                                     input logic [2:0] s);
      op_of = i2crsp_pkg::OP_FIN;
      if (k == i2crsp_pkg::KIND_WRITE) begin
         unique case (s)
            3'h0: op_of = i2crsp_pkg::OP_START;
            3'h1: op_of = i2crsp_pkg::OP_ADDRW;
            3'h2: op_of = i2crsp_pkg::OP_REG;
            3'h3: op_of = i2crsp_pkg::OP_DATA;
            default: op_of = i2crsp_pkg::OP_FIN;
         endcase
      end else if (k == i2crsp_pkg::KIND_READ) begin
         unique case (s)
            3'h0: op_of = i2crsp_pkg::OP_START;
            3'h1: op_of = i2crsp_pkg::OP_ADDRW;
            3'h2: op_of = i2crsp_pkg::OP_REG;
            3'h3: op_of = i2crsp_pkg::OP_START;
            3'h4: op_of = i2crsp_pkg::OP_ADDRR;
            3'h5: op_of = i2crsp_pkg::OP_RX;
            default: op_of = i2crsp_pkg::OP_FIN;
         endcase
      end else begin
         // Short read relies on the pointer the device retained
         unique case (s)
            3'h0: op_of = i2crsp_pkg::OP_START;
            3'h1: op_of = i2crsp_pkg::OP_ADDRR;
            3'h2: op_of = i2crsp_pkg::OP_RX;
            default: op_of = i2crsp_pkg::OP_FIN;
         endcase
      end
   endfunction : op_of

   assign tick  = (qcnt == '0);
   assign op    = op_of(kind, step);
   assign is_rx = (op == i2crsp_pkg::OP_RX);

   always_comb begin
      next_state    = state;
      next_qcnt     = tick ? qtr_of(fast) : qcnt - 1'b1;
      next_phase    = phase;
      next_step     = step;
      next_bitcnt   = bitcnt;
      next_shreg    = shreg;
      next_rdata    = rdata;
      next_kind     = kind;
      next_addr_sel = addr_sel;
      next_regb     = regb;
      next_datab    = datab;
      next_fast     = fast;
      next_stop     = stop;
      next_scl_low  = scl_low;
      next_sda_low  = sda_low;
      next_nack     = nack;
      next_done     = 1'b0;
      adv           = 1'b0;
      nop           = i2crsp_pkg::OP_FIN;
      unique case (state)
         i2crsp_pkg::ST_IDLE: begin
            if (cmd_valid_in) begin
               next_kind     = cmd_kind_in;
               next_addr_sel = cmd_addr_sel_in;
               next_regb     = cmd_reg_in;
               next_datab    = cmd_data_in;
               next_fast     = cmd_fast_in;
               next_stop     = cmd_stop_in;
               next_nack     = 1'b0;
               next_step     = i2crsp_pkg::STEP_RST;
               next_phase    = i2crsp_pkg::PHASE_RST;
               next_qcnt     = qtr_of(cmd_fast_in);
               next_state    = i2crsp_pkg::ST_START;
            end
         end
         i2crsp_pkg::ST_START: begin
            if (tick) begin
               next_phase = phase + 1'b1;
               unique case (phase)
                  2'h0: next_sda_low = 1'b0;
                  2'h1: next_scl_low = 1'b0;
                  2'h2: next_sda_low = 1'b1;
                  2'h3: begin
                     next_scl_low = 1'b1;
                     adv          = 1'b1;
                  end
               endcase
            end
         end
         i2crsp_pkg::ST_BIT: begin
            if (tick) begin
               next_phase = phase + 1'b1;
               unique case (phase)
                  2'h0: begin
                     // Change data only with the clock held low
                     if (bitcnt == i2crsp_pkg::BIT_ACK) begin
                        next_sda_low = is_rx;
                     end else begin
                        next_sda_low = is_rx ? 1'b0 : ~shreg[7];
                     end
                  end
                  2'h1: next_scl_low = 1'b0;
                  2'h2: begin
                     if (bitcnt == i2crsp_pkg::BIT_ACK) begin
                        if (!is_rx) begin
                           next_nack = sda_sync;
                        end
                     end else if (is_rx) begin
                        next_shreg = {shreg[6:0], sda_sync};
                     end
                  end
                  2'h3: begin
                     next_scl_low = 1'b1;
                     if (bitcnt == i2crsp_pkg::BIT_ACK) begin
                        if (is_rx) begin
                           next_rdata = shreg;
                        end
                        if (nack) begin
                           next_state = i2crsp_pkg::ST_STOP;
                        end else begin
                           adv = 1'b1;
                        end
                     end else begin
                        next_bitcnt = bitcnt + 1'b1;
                        if (!is_rx) begin
                           next_shreg = {shreg[6:0], 1'b0};
                        end
                     end
                  end
               endcase
            end
         end
         i2crsp_pkg::ST_STOP: begin
            if (tick) begin
               next_phase = phase + 1'b1;
               unique case (phase)
                  2'h0: next_sda_low = 1'b1;
                  2'h1: next_scl_low = 1'b0;
                  2'h2: next_sda_low = 1'b0;
                  2'h3: begin
                     next_done  = 1'b1;
                     next_state = i2crsp_pkg::ST_IDLE;
                  end
               endcase
            end
         end
      endcase
      if (adv) begin
         next_step   = step + 1'b1;
         nop         = op_of(kind, step + 1'b1);
         next_phase  = i2crsp_pkg::PHASE_RST;
         next_bitcnt = 4'h0;
         next_state  = i2crsp_pkg::ST_BIT;
         unique case (nop)
            i2crsp_pkg::OP_START: next_state = i2crsp_pkg::ST_START;
            i2crsp_pkg::OP_ADDRW: begin
               next_shreg = {i2crsp_pkg::ADDR_PREFIX, addr_sel,
                             i2crsp_pkg::DIR_WRITE};
            end
            i2crsp_pkg::OP_ADDRR: begin
               next_shreg = {i2crsp_pkg::ADDR_PREFIX, addr_sel,
                             i2crsp_pkg::DIR_READ};
            end
            i2crsp_pkg::OP_REG:  next_shreg = regb;
            i2crsp_pkg::OP_DATA: next_shreg = datab;
            i2crsp_pkg::OP_RX:   next_shreg = i2crsp_pkg::BYTE_RST;
            i2crsp_pkg::OP_FIN: begin
               // Without stop the bus stays held for a repeated start
               if (stop) begin
                  next_state = i2crsp_pkg::ST_STOP;
               end else begin
                  next_state = i2crsp_pkg::ST_IDLE;
                  next_done  = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state    <= i2crsp_pkg::ST_IDLE;
         qcnt     <= '0;
         phase    <= i2crsp_pkg::PHASE_RST;
         step     <= i2crsp_pkg::STEP_RST;
         bitcnt   <= 4'h0;
         shreg    <= i2crsp_pkg::BYTE_RST;
         rdata    <= i2crsp_pkg::BYTE_RST;
         kind     <= i2crsp_pkg::KIND_WRITE;
         addr_sel <= 2'h0;
         regb     <= i2crsp_pkg::BYTE_RST;
         datab    <= i2crsp_pkg::BYTE_RST;
         fast     <= 1'b0;
         stop     <= 1'b0;
         scl_low  <= 1'b0;
         sda_low  <= 1'b0;
         nack     <= 1'b0;
         done     <= 1'b0;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         state    <= next_state;
         qcnt     <= next_qcnt;
         phase    <= next_phase;
         step     <= next_step;
         bitcnt   <= next_bitcnt;
         shreg    <= next_shreg;
         rdata    <= next_rdata;
         kind     <= next_kind;
         addr_sel <= next_addr_sel;
         regb     <= next_regb;
         datab    <= next_datab;
         fast     <= next_fast;
         stop     <= next_stop;
         scl_low  <= next_scl_low;
         sda_low  <= next_sda_low;
         nack     <= next_nack;
         done     <= next_done;
         sda_meta <= sda_in;
         sda_sync <= sda_meta;
      end
   end

   assign cmd_ready_out = (state == i2crsp_pkg::ST_IDLE);
   assign done_out      = done;
   assign nack_out      = nack;
   assign rdata_out     = rdata;
   assign busy_out      = (state != i2crsp_pkg::ST_IDLE) | scl_low;
   assign scl_out       = 1'b0;
   assign scl_oe_out    = scl_low;
   assign sda_out       = 1'b0;
   assign sda_oe_out    = sda_low;

endmodule : i2crsp_master
`default_nettype wire

// [testbench/i2crsp_chk.sv]
// Checker for the command handshake and the bus timing of the master
`timescale 1ns/1ns
`default_nettype none
module i2crsp_chk (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic cmd_valid_in,
   input wire logic cmd_ready_out,
   input wire logic done_out,
   input wire logic nack_out,
   input wire logic busy_out,
   input wire logic scl_out,
   input wire logic scl_oe_out,
   input wire logic sda_out,
   input wire logic sda_oe_out
);
   // Shortest clock level: two fast quarters of 63 cycles, six cycles slack
   localparam int HI_MIN = 120;
   logic [15:0] lvl_cnt;
   logic [15:0] next_lvl_cnt;
   logic        prev_oe;
   always_comb begin
      next_lvl_cnt = (scl_oe_out != prev_oe) ? 16'h0001 : lvl_cnt + 16'h0001;
      if (lvl_cnt == 16'hffff) next_lvl_cnt = lvl_cnt;
   end
   always_ff @(posedge clk_sys_in) begin
      lvl_cnt <= sys_rst_in ? 16'h0000 : next_lvl_cnt;
      prev_oe <= sys_rst_in ? 1'b0 : scl_oe_out;
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_take; cmd_valid_in && cmd_ready_out; endsequence
   sequence s_start; $rose(sda_oe_out) && !scl_oe_out; endsequence
   sequence s_stop; $fell(sda_oe_out) && !scl_oe_out; endsequence
   scl_rate_a: assert property (scl_oe_out != prev_oe |-> lvl_cnt >= HI_MIN)
      else $error("clock level shorter than allowed");
   open_drain_a: assert property (!scl_out && !sda_out)
      else $error("line driven high");
   take_busy_a: assert property (s_take |=> busy_out && !cmd_ready_out)
      else $error("command taken but not busy");
   nack_clear_a: assert property (s_take |=> !nack_out)
      else $error("nack not cleared");
   take_start_a: assert property (s_take |-> ##[1:1000] (scl_oe_out || sda_oe_out))
      else $error("no bus activity after command");
   start_low_a: assert property (s_start |-> ##[1:300] scl_oe_out)
      else $error("clock not lowered after start");
   stop_idle_a: assert property (s_stop |=> (!scl_oe_out && !sda_oe_out) [*8])
      else $error("bus not idle after stop");
   done_pulse_a: assert property (done_out |=> !done_out)
      else $error("done longer than one cycle");
   done_ready_a: assert property (done_out |-> cmd_ready_out)
      else $error("not ready at done");
endmodule : i2crsp_chk
`default_nettype wire

// [testbench/i2crsp_dev.sv]
// Behavioural register device answering the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module i2crsp_dev #(
   parameter logic [1:0] ADDR_SEL = 2'h3
) (
   input wire logic scl_in,
   input wire logic sda_in,
   output logic     sda_oe_out
);
   // No clock output at all: the device only listens to the clock
   logic [7:0] regs [256];
   logic [7:0] ptr, shf, txd;
   logic       me, rd;
   int         bits, ph;
   initial begin
      sda_oe_out = 1'b0;
      ptr = 8'h00;
      me = 1'b0;
      rd = 1'b0;
      bits = 0;
      ph = 0;
      foreach (regs[i]) regs[i] = 8'h00;
   end
   always @(negedge sda_in) if (scl_in) begin bits = 0; ph = 0; end
   always @(posedge sda_in) if (scl_in) begin ph = 0; me = 1'b0; end
   always @(posedge scl_in) begin
      if (bits < 8) shf = {shf[6:0], sda_in};
      bits++;
   end
   always @(negedge scl_in) begin
      sda_oe_out = 1'b0;
      if (bits == 8) begin
         if (ph == 0) begin
            me = (shf[7:1] == {i2crsp_pkg::ADDR_PREFIX, ADDR_SEL});
            rd = shf[0];
            txd = regs[ptr];
         end else if (me && ph == 1 && !rd) ptr = shf;
         else if (me && ph == 2 && !rd) regs[ptr] = shf;
         sda_oe_out = me && !(rd && ph > 0);
      end else if (bits == 9) begin
         bits = 0;
         ph++;
      end
      if (me && rd && ph == 1 && bits < 8) sda_oe_out = !txd[7 - bits];
   end
endmodule : i2crsp_dev
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench: bus master against a behavioural register device
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic       clk, rst, cmd_valid, cmd_fast, cmd_stop, ready, done, nack, busy;
   logic [1:0] cmd_kind, cmd_sel;
   logic [7:0] cmd_reg, cmd_data, rdata;
   logic       scl_oe, sda_oe, dev_oe;
   wire        scl_w, sda_w;
   int         failures, cmp_count;
   // Both lines have pull-ups
   assign scl_w = !scl_oe;
   assign sda_w = !(sda_oe || dev_oe);
   i2crsp_master i_dut (
      .clk_sys_in(clk), .sys_rst_in(rst), .cmd_valid_in(cmd_valid),
      .cmd_ready_out(ready), .cmd_kind_in(cmd_kind), .cmd_addr_sel_in(cmd_sel),
      .cmd_reg_in(cmd_reg), .cmd_data_in(cmd_data), .cmd_fast_in(cmd_fast),
      .cmd_stop_in(cmd_stop), .done_out(done), .nack_out(nack), .rdata_out(rdata),
      .busy_out(busy), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w),
      .sda_out(), .sda_oe_out(sda_oe));
   i2crsp_dev #(.ADDR_SEL(2'h3)) i_dev (.scl_in(scl_w), .sda_in(sda_w), .sda_oe_out(dev_oe));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask : chk
   task automatic run(input logic [1:0] k, s, input logic [7:0] r, d, input logic f, p);
      int n;
      cmd_kind = k;
      cmd_sel = s;
      cmd_reg = r;
      cmd_data = d;
      cmd_fast = f;
      cmd_stop = p;
      cmd_valid = 1'b1;
      // Ready is looked at off the edge; the request stands through the taking edge
      while (ready !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1 cmd_valid = 1'b0;
      n = 0;
      do begin @(posedge clk); #1; n++; end while (done !== 1'b1 && n < 40000);
      chk("done", 8'h01, {7'h00, done});
   endtask : run
   task automatic t_idle();
      chk("idle lines", 8'h04, {5'h00, ready, busy, scl_oe | sda_oe});
      $display("test idle finished");
   endtask : t_idle
   task automatic t_write_std();
      run(2'h0, 2'h3, 8'h6d, 8'h92, 1'b0, 1'b1);
      chk("write nack", 8'h00, {7'h00, nack});
      chk("stored byte", 8'h92, i_dev.regs[8'h6d]);
      $display("test write_std finished");
   endtask : t_write_std
   task automatic t_read_fast();
      run(2'h1, 2'h3, 8'h6d, 8'h00, 1'b1, 1'b1);
      chk("read nack", 8'h00, {7'h00, nack});
      chk("read byte", 8'h92, rdata);
      $display("test read_fast finished");
   endtask : t_read_fast
   task automatic t_short();
      run(2'h0, 2'h3, 8'h10, 8'h5a, 1'b1, 1'b0);
      chk("bus held", 8'h01, {7'h00, busy});
      run(2'h2, 2'h3, 8'h00, 8'h00, 1'b1, 1'b1);
      chk("short read", 8'h5a, rdata);
      $display("test short finished");
   endtask : t_short
   task automatic t_nack();
      run(2'h0, 2'h2, 8'h6d, 8'h00, 1'b1, 1'b1);
      chk("wrong address nack", 8'h01, {7'h00, nack});
      chk("register kept", 8'h92, i_dev.regs[8'h6d]);
      run(2'h2, 2'h3, 8'h00, 8'h00, 1'b1, 1'b1);
      chk("pointer kept", 8'h5a, rdata);
      $display("test nack finished");
   endtask : t_nack
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   initial begin
      // All tests together need about 60000 cycles
      #800_000;
      failures++;
      give_verdict();
   end
   initial begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_kind = 2'h0;
      cmd_sel = 2'h0;
      cmd_reg = 8'h00;
      cmd_data = 8'h00;
      cmd_fast = 1'b0;
      cmd_stop = 1'b1;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      t_idle();
      t_write_std();
      t_read_fast();
      t_short();
      t_nack();
      give_verdict();
   end
endmodule : testbench
bind i2crsp_master i2crsp_chk i_chk (
   .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
   .cmd_ready_out(cmd_ready_out), .done_out(done_out), .nack_out(nack_out),
   .busy_out(busy_out), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out));
`default_nettype wire
